// [logic/srap_defs.svh]
`ifndef SRAP_DEFS_SVH
`define SRAP_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// writable registers: {address, reset value}
`define SRAP_R_INTERFACE_SETUP_A          {15'h0000, 8'h30}
`define SRAP_R_USER_SERIAL_SETUP          {15'h0001, 8'h00}
`define SRAP_R_DEVICE_OPERATING_SETUP     {15'h0002, 8'h00}
`define SRAP_R_CLOCKING_CONTROL_0         {15'h0010, 8'h80}
`define SRAP_R_FULL_SCALE_ADJUST_LO       {15'h0020, 8'h00}
`define SRAP_R_FULL_SCALE_ADJUST_HI       {15'h0021, 8'hA0}
`define SRAP_R_CLOCKING_CONTROL_1         {15'h0022, 8'h00}
`define SRAP_R_CLOCKING_CONTROL_2         {15'h0023, 8'h10}
`define SRAP_R_POWER_SAVING_1             {15'h0030, 8'h48}
`define SRAP_R_TIMESTAMP_CONTROL          {15'h003B, 8'h00}
`define SRAP_R_PLL_REFERENCE_OUT_CONTROL  {15'h003C, 8'h01}
`define SRAP_R_SYNTH_FEEDBACK_DIV_VP      {15'h003D, 8'h00}
`define SRAP_R_SYNTH_FEEDBACK_DIV_N       {15'h003E, 8'h20}
`define SRAP_R_SYNTH_OSCILLATOR_CONTROL   {15'h003F, 8'h4F}
`define SRAP_R_SERIALIZER_PREEMPHASIS     {15'h0048, 8'h00}
`define SRAP_R_TRIGGER_OUTPUT_CONTROL     {15'h0057, 8'h00}
`define SRAP_R_SYNTH_PIN_OVERRIDE         {15'h0058, 8'h00}
`define SRAP_R_OSCILLATOR_FREQUENCY_TRIM  {15'h0059, 8'h00}
`define SRAP_R_SYNTH_CALIBRATION_RESET    {15'h005C, 8'h00}
`define SRAP_R_OSCILLATOR_CAL_CONTROL     {15'h005D, 8'h40}
`define SRAP_R_CALIBRATION_ENABLE         {15'h0061, 8'h01}
`define SRAP_R_CALIBRATION_SETUP_0        {15'h0062, 8'h01}
`define SRAP_R_CALIBRATION_SETUP_1        {15'h0065, 8'h01}
`define SRAP_R_CALIBRATION_AVERAGING      {15'h0068, 8'h61}
`define SRAP_R_CALIBRATION_PIN_SETUP      {15'h006B, 8'h00}
`define SRAP_R_CALIBRATION_SOFTWARE_TRIG  {15'h006C, 8'h01}
`define SRAP_R_LOW_POWER_BACKGROUND_CAL   {15'h006E, 8'h88}
`define SRAP_R_GAIN_DAC_TRIM              {15'h007A, 8'h00}
`define SRAP_R_BANDGAP_TRIM               {15'h007C, 8'h00}
`define SRAP_R_TERMINATION_TRIM_A         {15'h007E, 8'h00}
`define SRAP_R_TERMINATION_TRIM_B         {15'h007F, 8'h00}
`define SRAP_R_TERMINATION_TRIM_C         {15'h0080, 8'h00}
`define SRAP_R_TERMINATION_TRIM_D         {15'h0081, 8'h00}
`define SRAP_R_CONVERTER_SOURCE_DELAY     {15'h009A, 8'h00}
`define SRAP_R_MUX_SELECT_DELAY           {15'h009B, 8'h00}
`define SRAP_R_DITHER_CONTROL             {15'h009D, 8'h00}
`define SRAP_R_LSB_OUTPUT_CONTROL         {15'h0160, 8'h00}
`define SRAP_R_SERIAL_LINK_ENABLE         {15'h0200, 8'h01}
`define SRAP_R_LINK_MODE_SELECT           {15'h0201, 8'h00}
`define SRAP_RW_COUNT                     39

`define SRAP_RW_TABLE '{ \
	`SRAP_R_INTERFACE_SETUP_A, `SRAP_R_USER_SERIAL_SETUP, `SRAP_R_DEVICE_OPERATING_SETUP, \
	`SRAP_R_CLOCKING_CONTROL_0, `SRAP_R_FULL_SCALE_ADJUST_LO, `SRAP_R_FULL_SCALE_ADJUST_HI, \
	`SRAP_R_CLOCKING_CONTROL_1, `SRAP_R_CLOCKING_CONTROL_2, `SRAP_R_POWER_SAVING_1, \
	`SRAP_R_TIMESTAMP_CONTROL, `SRAP_R_PLL_REFERENCE_OUT_CONTROL, \
	`SRAP_R_SYNTH_FEEDBACK_DIV_VP, `SRAP_R_SYNTH_FEEDBACK_DIV_N, \
	`SRAP_R_SYNTH_OSCILLATOR_CONTROL, `SRAP_R_SERIALIZER_PREEMPHASIS, \
	`SRAP_R_TRIGGER_OUTPUT_CONTROL, `SRAP_R_SYNTH_PIN_OVERRIDE, \
	`SRAP_R_OSCILLATOR_FREQUENCY_TRIM, `SRAP_R_SYNTH_CALIBRATION_RESET, \
	`SRAP_R_OSCILLATOR_CAL_CONTROL, `SRAP_R_CALIBRATION_ENABLE, `SRAP_R_CALIBRATION_SETUP_0, \
	`SRAP_R_CALIBRATION_SETUP_1, `SRAP_R_CALIBRATION_AVERAGING, \
	`SRAP_R_CALIBRATION_PIN_SETUP, `SRAP_R_CALIBRATION_SOFTWARE_TRIG, \
	`SRAP_R_LOW_POWER_BACKGROUND_CAL, `SRAP_R_GAIN_DAC_TRIM, `SRAP_R_BANDGAP_TRIM, \
	`SRAP_R_TERMINATION_TRIM_A, `SRAP_R_TERMINATION_TRIM_B, `SRAP_R_TERMINATION_TRIM_C, \
	`SRAP_R_TERMINATION_TRIM_D, `SRAP_R_CONVERTER_SOURCE_DELAY, `SRAP_R_MUX_SELECT_DELAY, \
	`SRAP_R_DITHER_CONTROL, `SRAP_R_LSB_OUTPUT_CONTROL, `SRAP_R_SERIAL_LINK_ENABLE, \
	`SRAP_R_LINK_MODE_SELECT }

// read-only register addresses
`define SRAP_A_MAKER_ID_LO                15'h000C
`define SRAP_A_MAKER_ID_HI                15'h000D
`define SRAP_A_SYSREF_CAPTURE_POSITION    15'h002C
`define SRAP_A_OSCILLATOR_CAL_STATE       15'h005E
`define SRAP_A_CALIBRATION_STATE          15'h006A

// frame layout and control fields
`define SRAP_HDR_LAST                     4'hF
`define SRAP_BYTE_LAST                    4'h7
`define SRAP_IDX_SETUP_A                  0
`define SRAP_IDX_USER_SETUP               1
`define SRAP_STEP_UP_BIT                  5
`define SRAP_HOLD_BIT                     0

////////////////////////////////////////////////////////////////////////////////
// host command port
`define SRAP_H_FRAME                      2'h0
`define SRAP_H_START                      2'h1
`define SRAP_H_DATA                       2'h2
`define SRAP_H_STATUS                     2'h3
`define SRAP_H_BUSY_BIT                   0
`define SRAP_H_TX_FULL_BIT                1
`define SRAP_H_RX_VALID_BIT               2
`define SRAP_H_REFUSED_BIT                3
`define SRAP_SCLK_HALF_DEF                8

`endif

// [logic/srap_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "srap_defs.svh"
module srap_device #(
	// arbitrary neutral value
	parameter logic [15:0] MAKER_ID = 16'h5A5A
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset_n,
	srap_if.device          link,
	input  wire logic [7:0] i_sysref_position,
	input  wire logic [7:0] i_osc_cal_state,
	input  wire logic [7:0] i_cal_state,
	output logic            o_frame_active,
	output logic            o_wr_pulse,
	output logic [14:0]     o_wr_addr,
	output logic [7:0]      o_wr_data
);
	localparam logic [22:0] RW_MAP [`SRAP_RW_COUNT] = `SRAP_RW_TABLE;

	srap_pkg::srap_dev_phase_t phase;
	logic [2:0]  sync_a;
	logic [2:0]  sync_b;
	logic        clk_d;
	logic        cs_n_s;
	logic        clk_s;
	logic        din_s;
	logic        rise;
	logic        fall;
	logic [3:0]  cnt;
	logic [15:0] hdr;
	logic [14:0] addr;
	logic        is_read;
	logic [7:0]  dsh;
	logic [7:0]  osh;
	logic        oe;
	logic [7:0]  regs [`SRAP_RW_COUNT];
	logic        hit;
	logic [5:0]  hit_idx;
	logic [7:0]  rd_byte;
	logic [7:0]  wr_byte;
	logic        byte_end;
	logic        wr_now;
	logic        step_up;
	logic        hold;

	////////////////////////////////////////////////////////////////////////////////
	// pins cross into the system clock through two stages
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_a <= 3'b100;
			sync_b <= 3'b100;
			clk_d  <= 1'b0;
		end else begin
			sync_a <= {link.chip_select_n, link.serial_clock, link.serial_data_in};
			sync_b <= sync_a;
			clk_d  <= sync_b[1];
		end
	end

	assign cs_n_s = sync_b[2];
	assign clk_s  = sync_b[1];
	assign din_s  = sync_b[0];

	assign rise = !cs_n_s && clk_s && !clk_d;
	assign fall = !cs_n_s && !clk_s && clk_d;

	assign byte_end = rise && phase == srap_pkg::srap_dph_data && cnt == `SRAP_BYTE_LAST;
	assign wr_byte  = {dsh[6:0], din_s};
	assign step_up  = regs[`SRAP_IDX_SETUP_A][`SRAP_STEP_UP_BIT];
	assign hold     = regs[`SRAP_IDX_USER_SETUP][`SRAP_HOLD_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// frame engine
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase   <= srap_pkg::srap_dph_idle;
			cnt     <= 4'h0;
			hdr     <= 16'h0000;
			addr    <= 15'h0000;
			is_read <= 1'b0;
			dsh     <= 8'h00;
		end else if (cs_n_s) begin
			phase <= srap_pkg::srap_dph_idle;
			cnt   <= 4'h0;
		end else if (rise) begin
			case (phase)
				srap_pkg::srap_dph_idle,
				srap_pkg::srap_dph_header: begin
					hdr   <= {hdr[14:0], din_s};
					cnt   <= cnt + 4'h1;
					phase <= srap_pkg::srap_dph_header;
					if (cnt == `SRAP_HDR_LAST) begin
						is_read <= hdr[14];
						addr    <= {hdr[13:0], din_s};
						cnt     <= 4'h0;
						phase   <= srap_pkg::srap_dph_data;
					end
				end
				srap_pkg::srap_dph_data: begin
					dsh <= wr_byte;
					cnt <= cnt + 4'h1;
					if (cnt == `SRAP_BYTE_LAST) begin
						cnt <= 4'h0;
						if (!hold) begin
							addr <= step_up ? addr + 15'h0001 : addr - 15'h0001;
						end
					end
				end
				default: begin
					phase <= srap_pkg::srap_dph_idle;
					cnt   <= 4'h0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// address decode
	always_comb begin
		hit     = 1'b0;
		hit_idx = 6'h00;
		for (int i = 0; i < `SRAP_RW_COUNT; i++) begin
			if (RW_MAP[i][22:8] == addr) begin
				hit     = 1'b1;
				hit_idx = 6'(i);
			end
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (hit) begin
			rd_byte = regs[hit_idx];
		end else begin
			case (addr)
				`SRAP_A_MAKER_ID_LO:             rd_byte = MAKER_ID[7:0];
				`SRAP_A_MAKER_ID_HI:             rd_byte = MAKER_ID[15:8];
				`SRAP_A_SYSREF_CAPTURE_POSITION: rd_byte = i_sysref_position;
				`SRAP_A_OSCILLATOR_CAL_STATE:    rd_byte = i_osc_cal_state;
				`SRAP_A_CALIBRATION_STATE:       rd_byte = i_cal_state;
				default:                         rd_byte = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// store only after eighth bit
	assign wr_now = byte_end && !is_read && hit;

	// read-only and unlisted addresses drop writes
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < `SRAP_RW_COUNT; i++) begin
				regs[i] <= RW_MAP[i][7:0];
			end
		end else if (wr_now) begin
			regs[hit_idx] <= wr_byte;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wr_pulse <= 1'b0;
			o_wr_addr  <= 15'h0000;
			o_wr_data  <= 8'h00;
		end else begin
			o_wr_pulse <= wr_now;
			if (wr_now) begin
				o_wr_addr <= addr;
				o_wr_data <= wr_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output changes on the fall so the host sees it settled at the next rise
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			osh <= 8'h00;
			oe  <= 1'b0;
		end else if (cs_n_s) begin
			osh <= 8'h00;
			oe  <= 1'b0;
		end else if (fall && phase == srap_pkg::srap_dph_data && is_read) begin
			if (cnt == 4'h0) begin
				osh <= rd_byte;
				oe  <= 1'b1;
			end else begin
				osh <= {osh[6:0], 1'b0};
			end
		end
	end

	// enable only in read data bits
	assign link.data_out_en    = oe;
	assign link.data_out_drive = osh[7];
	assign o_frame_active      = !cs_n_s;
endmodule : srap_device
`default_nettype wire

// [logic/srap_host.sv]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "srap_defs.svh"
module srap_host #(
	parameter int unsigned SCLK_HALF = `SRAP_SCLK_HALF_DEF
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	srap_if.host             link,
	input  wire logic        i_cal_running,
	input  wire logic [1:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata
);
	if (SCLK_HALF < 4 || SCLK_HALF > 255) begin : g_chk
		$error("srap_host: SCLK_HALF must lie in 4..255");
	end

	localparam logic [22:0] RW_MAP [`SRAP_RW_COUNT] = `SRAP_RW_TABLE;
	localparam logic [7:0]  HALF_LAST = 8'(SCLK_HALF - 1);

	srap_pkg::srap_host_state_t state;
	logic [1:0]  dout_sync;
	logic [7:0]  div_cnt;
	logic        tick;
	logic [15:0] frame_word;
	logic [7:0]  count;
	logic [7:0]  bytes_left;
	logic [7:0]  tx;
	logic        tx_full;
	logic [7:0]  rx;
	logic        rx_valid;
	logic        refused;
	logic [15:0] sh;
	logic [3:0]  bit_idx;
	logic        in_data;
	logic        is_read;
	logic        clk_q;
	logic        cs_q;
	logic        listed;
	logic        start_req;
	logic        allowed;
	logic        take_tx;
	logic        rx_done;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dout_sync <= 2'h0;
		end else begin
			dout_sync <= {dout_sync[0], link.serial_data_out};
		end
	end

	// divider restarts on leaving the gate so no phase is cut short
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_cnt <= 8'h00;
		end else if (state == srap_pkg::srap_hst_idle || state == srap_pkg::srap_hst_gate || tick) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end
	assign tick = (div_cnt == HALF_LAST);

	always_comb begin
		listed = 1'b0;
		for (int i = 0; i < `SRAP_RW_COUNT; i++) begin
			if (RW_MAP[i][22:8] == frame_word[14:0]) begin
				listed = 1'b1;
			end
		end
	end

	assign start_req = i_wr && i_addr == `SRAP_H_START && state == srap_pkg::srap_hst_idle;
	assign allowed   = !i_cal_running && (frame_word[15] || listed);
	assign take_tx   = state == srap_pkg::srap_hst_gate && !is_read && tx_full;
	assign rx_done   = state == srap_pkg::srap_hst_high && tick && in_data && is_read
		&& bit_idx == `SRAP_BYTE_LAST;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state      <= srap_pkg::srap_hst_idle;
			cs_q       <= 1'b1;
			clk_q      <= 1'b0;
			sh         <= 16'h0000;
			bit_idx    <= 4'h0;
			in_data    <= 1'b0;
			is_read    <= 1'b0;
			bytes_left <= 8'h00;
		end else begin
			case (state)
				srap_pkg::srap_hst_idle: begin
					if (start_req && allowed) begin
						cs_q       <= 1'b0;
						sh         <= frame_word;
						is_read    <= frame_word[15];
						bytes_left <= i_wdata[7:0];
						bit_idx    <= 4'h0;
						in_data    <= 1'b0;
						state      <= srap_pkg::srap_hst_low;
					end
				end
				srap_pkg::srap_hst_low: begin
					if (tick) begin
						clk_q <= 1'b1;
						state <= srap_pkg::srap_hst_high;
					end
				end
				srap_pkg::srap_hst_high: begin
					if (tick) begin
						clk_q <= 1'b0;
						sh    <= {sh[14:0], dout_sync[1]};
						if (!in_data && bit_idx == `SRAP_HDR_LAST) begin
							in_data <= 1'b1;
							bit_idx <= 4'h0;
							state   <= srap_pkg::srap_hst_gate;
						end else if (in_data && bit_idx == `SRAP_BYTE_LAST) begin
							bit_idx <= 4'h0;
							if (bytes_left == 8'h00) begin
								state <= srap_pkg::srap_hst_trail;
							end else begin
								bytes_left <= bytes_left - 8'h01;
								state      <= srap_pkg::srap_hst_gate;
							end
						end else begin
							bit_idx <= bit_idx + 4'h1;
							state   <= srap_pkg::srap_hst_low;
						end
					end
				end
				// stalls the serial clock: the device has no lower rate limit
				srap_pkg::srap_hst_gate: begin
					if (is_read ? !rx_valid : tx_full) begin
						sh[15:8] <= is_read ? 8'h00 : tx;
						state    <= srap_pkg::srap_hst_low;
					end
				end
				srap_pkg::srap_hst_trail: begin
					if (tick) begin
						cs_q  <= 1'b1;
						state <= srap_pkg::srap_hst_gap;
					end
				end
				srap_pkg::srap_hst_gap: begin
					if (tick) begin
						state <= srap_pkg::srap_hst_idle;
					end
				end
				default: begin
					state <= srap_pkg::srap_hst_idle;
					cs_q  <= 1'b1;
					clk_q <= 1'b0;
				end
			endcase
		end
	end

	assign link.serial_clock   = clk_q;
	assign link.chip_select_n  = cs_q;
	assign link.serial_data_in = sh[15];

	////////////////////////////////////////////////////////////////////////////////
	// set wins over clear on every flag
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			frame_word <= 16'h0000;
			count      <= 8'h00;
			tx         <= 8'h00;
			tx_full    <= 1'b0;
			rx         <= 8'h00;
			rx_valid   <= 1'b0;
			refused    <= 1'b0;
		end else begin
			if (i_wr && i_addr == `SRAP_H_FRAME) begin
				frame_word <= i_wdata;
			end
			if (start_req) begin
				count   <= i_wdata[7:0];
				refused <= !allowed;
			end
			if (i_wr && i_addr == `SRAP_H_DATA) begin
				tx      <= i_wdata[7:0];
				tx_full <= 1'b1;
			end else if (take_tx) begin
				tx_full <= 1'b0;
			end
			if (rx_done) begin
				rx       <= {sh[6:0], dout_sync[1]};
				rx_valid <= 1'b1;
			end else if (i_rd && i_addr == `SRAP_H_DATA) begin
				rx_valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			case (i_addr)
				`SRAP_H_FRAME:  o_rdata <= frame_word;
				`SRAP_H_START:  o_rdata <= {8'h00, count};
				`SRAP_H_DATA:   o_rdata <= {8'h00, rx};
				`SRAP_H_STATUS: o_rdata <= {12'h000, refused, rx_valid, tx_full,
					state != srap_pkg::srap_hst_idle};
				default:        o_rdata <= 16'h0000;
			endcase
		end else begin
			o_rdata <= 16'h0000;
		end
	end
endmodule : srap_host
`default_nettype wire

// [logic/srap_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface srap_if;
	logic serial_clock;
	logic chip_select_n;
	logic serial_data_in;
	logic data_out_drive;
	logic data_out_en;
	logic serial_data_out;

	// released line reads high, as with a pull-up
	assign serial_data_out = data_out_en ? data_out_drive : 1'b1;

	modport device (
		input  serial_clock,
		input  chip_select_n,
		input  serial_data_in,
		output data_out_drive,
		output data_out_en
	);
	modport host (
		output serial_clock,
		output chip_select_n,
		output serial_data_in,
		input  serial_data_out
	);
endinterface : srap_if
`default_nettype wire

// [logic/srap_pkg.sv]
package srap_pkg;
	typedef enum logic [1:0] {
		srap_dph_idle   = 2'b00,
		srap_dph_header = 2'b01,
		srap_dph_data   = 2'b10
	} srap_dev_phase_t;

	typedef enum logic [2:0] {
		srap_hst_idle  = 3'b000,
		srap_hst_low   = 3'b001,
		srap_hst_high  = 3'b010,
		srap_hst_gate  = 3'b011,
		srap_hst_trail = 3'b100,
		srap_hst_gap   = 3'b101
	} srap_host_state_t;
endpackage : srap_pkg

// [test/serial_register_access_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "srap_defs.svh"
module serial_register_access_port_tb;
	logic        sys_clk;
	logic        reset_n;
	logic        cal;
	logic [1:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        wr_pulse;
	logic [14:0] wr_addr;
	logic [7:0]  wr_data;
	logic [14:0] last_a;
	logic [7:0]  last_d;
	logic [7:0]  got [8];
	int          failures;
	int          cmp_count;
	int          cycles;
	int          n_wr;
	int          n_fr;
	logic        frame_act;
	logic        act_q;

	srap_if link ();
	srap_host #(.SCLK_HALF(8)) i_srap_host (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
		.link(link), .i_cal_running(cal), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata));
	// maker code is arbitrary
	srap_device #(.MAKER_ID(16'h1234)) i_srap_device (.i_sys_clk(sys_clk),
		.i_reset_n(reset_n), .link(link), .i_sysref_position(8'hC3),
		.i_osc_cal_state(8'h5E), .i_cal_state(8'h6A), .o_frame_active(frame_act),
		.o_wr_pulse(wr_pulse), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
	srap_assertions i_srap_assertions (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
		.serial_clock(link.serial_clock), .chip_select_n(link.chip_select_n),
		.serial_data_in(link.serial_data_in), .data_out_drive(link.data_out_drive),
		.data_out_en(link.data_out_en), .serial_data_out(link.serial_data_out));

	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	// store monitor and watchdog
	always @(posedge sys_clk) begin
		if (wr_pulse === 1'b1) begin
			n_wr++;
			last_a = wr_addr;
			last_d = wr_data;
		end
		if (frame_act === 1'b1 && act_q !== 1'b1) n_fr++;
		act_q = frame_act;
		cycles++;
		if (cycles == 60000) begin
			failures++;
			end_sim();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge sys_clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 q = rdata;
	endtask : bus

	task automatic poll(input int b, input logic v);
		logic [15:0] s;
		repeat (2000) begin
			bus(1'b0, `SRAP_H_STATUS, 16'h0000, s);
			if (s[b] === v) return;
		end
		check({7'h00, s[b]}, {7'h00, v}, "status wait");
	endtask : poll

	// one frame of n bytes; writes send d0, d0+1, ...
	task automatic xfer(input logic r, input logic [14:0] a, input int n, input logic [7:0] d0);
		logic [15:0] q;
		bus(1'b1, `SRAP_H_FRAME, {r, a}, q);
		if (!r) bus(1'b1, `SRAP_H_DATA, {8'h00, d0}, q);
		bus(1'b1, `SRAP_H_START, 16'(n - 1), q);
		for (int i = 0; i < n; i++) begin
			if (r) begin
				poll(`SRAP_H_RX_VALID_BIT, 1'b1);
				bus(1'b0, `SRAP_H_DATA, 16'h0000, q);
				got[i] = q[7:0];
			end else if (i < n - 1) begin
				poll(`SRAP_H_TX_FULL_BIT, 1'b0);
				bus(1'b1, `SRAP_H_DATA, {8'h00, d0 + 8'(i + 1)}, q);
			end
		end
		poll(`SRAP_H_BUSY_BIT, 1'b0);
	endtask : xfer

	task automatic rchk(input logic [14:0] a, input logic [7:0] exp);
		xfer(1'b1, a, 1, 8'h00);
		check(got[0], exp, "read back");
	endtask : rchk

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [22:0] tbl [7] = '{`SRAP_R_INTERFACE_SETUP_A, `SRAP_R_CLOCKING_CONTROL_0,
			`SRAP_R_SYNTH_OSCILLATOR_CONTROL, {15'h002C, 8'hC3}, {15'h006A, 8'h6A},
			{15'h0005, 8'h00}, {15'h005E, 8'h5E}};
		foreach (tbl[i]) rchk(tbl[i][22:8], tbl[i][7:0]);
		xfer(1'b1, 15'h000C, 2, 8'h00);
		check(got[0], 8'h34, "id low byte");
		check(got[1], 8'h12, "id high byte");
		xfer(1'b1, 15'h0020, 2, 8'h00);
		check(got[0], 8'h00, "range low byte");
		check(got[1], 8'hA0, "range high byte");
		$display("reset test done");
	endtask : t_reset

	task automatic t_write;
		int n0;
		int f0;
		n0 = n_wr;
		f0 = n_fr;
		xfer(1'b0, 15'h0010, 1, 8'hA5);
		check(8'(n_wr - n0), 8'h01, "store count");
		check(last_a[7:0], 8'h10, "store address");
		check(last_d, 8'hA5, "store data");
		rchk(15'h0010, 8'hA5);
		xfer(1'b0, 15'h0200, 2, 8'h3C);
		xfer(1'b1, 15'h0200, 2, 8'h00);
		check(got[0], 8'h3C, "stream up 0");
		check(got[1], 8'h3D, "stream up 1");
		check(8'(n_fr - f0), 8'h04, "frames seen");
		check({7'h00, frame_act}, 8'h00, "frame closed");
		$display("write test done");
	endtask : t_write

	task automatic t_steps;
		int n0;
		xfer(1'b0, 15'h0000, 1, 8'h10);
		xfer(1'b0, 15'h003F, 3, 8'h61);
		rchk(15'h003D, 8'h63);
		rchk(15'h003E, 8'h62);
		xfer(1'b0, 15'h0000, 1, 8'h30);
		xfer(1'b0, 15'h0001, 1, 8'h01);
		n0 = n_wr;
		xfer(1'b0, 15'h003B, 3, 8'h41);
		check(8'(n_wr - n0), 8'h03, "held stores");
		check(last_a[7:0], 8'h3B, "held address");
		check(last_d, 8'h43, "held data");
		rchk(15'h003C, 8'h01);
		xfer(1'b0, 15'h0001, 1, 8'h00);
		$display("address step test done");
	endtask : t_steps

	task automatic t_refuse;
		logic [15:0] q;
		int          n0;
		n0 = n_wr;
		@(posedge sys_clk);
		cal <= 1'b1;
		xfer(1'b0, 15'h0010, 1, 8'h77);
		bus(1'b0, `SRAP_H_STATUS, 16'h0000, q);
		check({7'h00, q[`SRAP_H_REFUSED_BIT]}, 8'h01, "cal refused");
		@(posedge sys_clk);
		cal <= 1'b0;
		// unlisted place is never written, only reads are let through
		xfer(1'b0, 15'h0005, 1, 8'h77);
		bus(1'b0, `SRAP_H_STATUS, 16'h0000, q);
		check({7'h00, q[`SRAP_H_REFUSED_BIT]}, 8'h01, "reserved refused");
		check(8'(n_wr - n0), 8'h00, "no store");
		rchk(15'h0010, 8'hA5);
		$display("refusal test done");
	endtask : t_refuse

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim

	initial begin
		reset_n = 1'b0;
		cal = 1'b0;
		addr = 2'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
		t_write();
		t_steps();
		t_refuse();
		end_sim();
	end
endmodule : serial_register_access_port_tb
`default_nettype wire

// [test/srap_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module srap_assertions (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic serial_data_in,
	input wire logic data_out_drive,
	input wire logic data_out_en,
	input wire logic serial_data_out
);
	logic       sclk_q;
	logic [7:0] rises;
	logic       is_read;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	////////////////////////////////////////////////////////////////////////////////
	// pin-level rise count, so header and data bits can be told apart
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sclk_q  <= 1'b0;
			rises   <= 8'h00;
			is_read <= 1'b0;
		end else begin
			sclk_q <= serial_clock;
			if (chip_select_n) begin
				rises <= 8'h00;
			end else if (serial_clock && !sclk_q) begin
				rises <= rises + 8'h01;
				if (rises == 8'h00) begin
					is_read <= serial_data_in;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// clock idle deselected
	sclk_idle_a: assert property (chip_select_n |-> !serial_clock)
		else $error("clock moved while deselected");
	sdi_hold_a: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_data_in))
		else $error("data in changed while clock high");
	half_width_a: assert property ($rose(serial_clock) |-> serial_clock[*4])
		else $error("clock high phase too short");
	header_quiet_a: assert property (!chip_select_n && rises < 8'h10 |-> !data_out_en)
		else $error("output driven during header");
	write_quiet_a: assert property (!chip_select_n && rises != 8'h00 && !is_read |-> !data_out_en)
		else $error("output driven in write frame");
	drive_start_a: assert property ($rose(data_out_en) |-> is_read && rises == 8'h10 && !serial_clock)
		else $error("output drive began at wrong bit");
	bit_hold_a: assert property (data_out_en && serial_clock && $past(serial_clock) |-> $stable(data_out_drive))
		else $error("read bit changed while clock high");
	frame_len_a: assert property ($rose(chip_select_n) |-> rises >= 8'h18 && rises[2:0] == 3'h0)
		else $error("frame length not whole bytes");
	release_a: assert property ($rose(chip_select_n) |-> ##[1:6] !data_out_en)
		else $error("output still driven after deselect");
	gap_a: assert property ($rose(chip_select_n) |-> chip_select_n[*4])
		else $error("select gap too short");
	line_idle_a: assert property (!data_out_en |-> serial_data_out)
		else $error("released data line not high");
endmodule : srap_assertions
`default_nettype wire
